// File: rtl/ata_host_port_cfg.svh
// Timing, sizing and reset constants for the disk host port
`ifndef ATA_HOST_PORT_CFG_SVH
`define ATA_HOST_PORT_CFG_SVH
`define ATA_CLK_PERIOD_NS 25
`define ATA_T_SETUP_NS 70
`define ATA_T_STROBE_NS 165
`define ATA_T_RECOV_NS 30
`define ATA_T_UDMA_HALF_NS 60
`define ATA_T_STOP_NS 100
// Least times round up to whole clock cycles
`define ATA_CYC(ns) ((ns + `ATA_CLK_PERIOD_NS - 1) / `ATA_CLK_PERIOD_NS)
`define ATA_DATA_W 16
`define ATA_FIFO_DEPTH 16
`define ATA_FIFO_SLACK 4
`define ATA_DATA_RESET 16'h0000
`endif

// File: rtl/ata_host_port_pkg.sv
// Types shared by the disk host port and its users
package ata_host_port_pkg;
    typedef enum logic [1:0] {
        MODE_PIO  = 2'h0,
        MODE_MDMA = 2'h1,
        MODE_UDMA = 2'h2
    } xfer_mode_e;
    typedef enum logic [1:0] {
        OP_REG_RD = 2'h0,
        OP_REG_WR = 2'h1,
        OP_DMA_RD = 2'h2,
        OP_DMA_WR = 2'h3
    } op_e;
    typedef struct packed {
        op_e         op;
        logic        ctlBlock;
        logic [2:0]  addr;
        logic [15:0] wdata;
        logic [15:0] count;
    } cmd_s;
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_SETUP  = 8'h02,
        ST_STROBE = 8'h04,
        ST_RECOV  = 8'h08,
        ST_UWAIT  = 8'h10,
        ST_URD    = 8'h20,
        ST_UWR    = 8'h40,
        ST_USTOP  = 8'h80
    } state_e;
endpackage

// File: rtl/ata_host_port.sv
// Parallel disk host port: PIO, multiword DMA and Ultra DMA engine with read FIFO
`timescale 1ns/1ps
`include "ata_host_port_cfg.svh"

// ****************************************************************
// Read data FIFO
// ****************************************************************
module ata_stream_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16,
    parameter int SLACK = 4
) (
    input  wire logic         clk,        // Core clock
    input  wire logic         rstB,       // Async reset, active low
    input  wire logic         inValid,    // Word offered
    output logic              inReady,    // Room for a word
    input  wire logic [W-1:0] inData,     // Word in
    output logic              outValid,   // Word available
    input  wire logic         outReady,   // Consumer takes word
    output logic [W-1:0]      outData,    // Oldest word
    output logic              almostFull  // SLACK or fewer free
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next, level;
    logic         push, pop;

    assign level      = wrPtr_reg - rdPtr_reg;
    assign inReady    = level != (AW+1)'(DEPTH);
    assign outValid   = level != '0;
    assign almostFull = level >= (AW+1)'(DEPTH - SLACK);
    assign outData    = mem[rdPtr_reg[AW-1:0]];
    assign push       = inValid && inReady;
    assign pop        = outValid && outReady;

    always_comb begin
        wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
        rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    end

    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
endmodule // ata_stream_fifo

module ata_host_port #(
    parameter int DATA_W = `ATA_DATA_W,
    parameter int DEPTH  = `ATA_FIFO_DEPTH
) (
    input  wire logic                           core_clk,     // 40 MHz core clock
    input  wire logic                           rst_b,        // Async reset, active low
    input  wire ata_host_port_pkg::xfer_mode_e  xferMode,     // Transfer mode setting
    input  wire logic                           cmdValid,     // Command offered
    output logic                                cmdReady,     // Command taken
    input  wire ata_host_port_pkg::cmd_s        cmd,          // Command contents
    input  wire logic                           wrValid,      // DMA write word offered
    output logic                                wrReady,      // DMA write word taken
    input  wire logic [DATA_W-1:0]              wrData,       // DMA write word
    output logic                                rdValid,      // Read word available
    input  wire logic                           rdReady,      // Read word taken
    output logic [DATA_W-1:0]                   rdData,       // Read word
    output logic                                busy,         // Transfer in progress
    output logic                                cmdBlockSelN, // Command block select
    output logic                                ctlBlockSelN, // Control block select
    output logic [2:0]                          regAddr,      // Register address
    input  wire logic [DATA_W-1:0]              diskDataIn,   // Data bus level
    output logic [DATA_W-1:0]                   diskDataOut,  // Data bus drive value
    output logic                                diskDataOe,   // Data bus drive enable
    input  wire logic                           dmaRequest,   // Drive DMA request
    output logic                                dmaAckN,      // DMA acknowledge
    output logic                                readStrobeN,  // Read strobe / Ultra pin
    output logic                                writeStrobeN, // Write strobe / stop
    input  wire logic                           channelReady  // Ready / Ultra pin
);
    import ata_host_port_pkg::*;

    localparam logic [7:0] SETUP_CYC  = 8'(`ATA_CYC(`ATA_T_SETUP_NS));
    localparam logic [7:0] STROBE_CYC = 8'(`ATA_CYC(`ATA_T_STROBE_NS));
    localparam logic [7:0] RECOV_CYC  = 8'(`ATA_CYC(`ATA_T_RECOV_NS));
    localparam logic [7:0] HALF_CYC   = 8'(`ATA_CYC(`ATA_T_UDMA_HALF_NS));
    localparam logic [7:0] STOP_CYC   = 8'(`ATA_CYC(`ATA_T_STOP_NS));
    localparam int         SW         = DATA_W + 2;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [SW-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
    logic          rdyEdge, rdyLvl, reqLvl;
    logic [DATA_W-1:0] dataS;

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_lvl
            // Change counts once stages two and three agree
            assign lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : lvl_reg[gi];
        end
    endgenerate
    assign rdyLvl  = lvl_reg[0];
    assign reqLvl  = lvl_reg[1];
    assign rdyEdge = lvl_next[0] != lvl_reg[0];
    assign dataS   = lvl_next[SW-1:2];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= {diskDataIn, dmaRequest, channelReady};
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    // ****************************************************************
    // Read FIFO
    // ****************************************************************
    logic              push_reg, push_next, fifoRoom, fifoAlmost;
    logic [DATA_W-1:0] pushData_reg, pushData_next;

    ata_stream_fifo #(.W(DATA_W), .DEPTH(DEPTH), .SLACK(`ATA_FIFO_SLACK)) u_fifo (
        .clk        (core_clk),
        .rstB       (rst_b),
        .inValid    (push_reg),
        .inReady    (fifoRoom),
        .inData     (pushData_reg),
        .outValid   (rdValid),
        .outReady   (rdReady),
        .outData    (rdData),
        .almostFull (fifoAlmost)
    );

    // ****************************************************************
    // Transfer engine
    // ****************************************************************
    state_e            state_reg, state_next;
    cmd_s              cmd_reg, cmd_next;
    logic [15:0]       words_reg, words_next;
    logic [7:0]        timer_reg, timer_next;
    logic [DATA_W-1:0] dout_reg, dout_next;
    logic              oe_reg, oe_next, rdN_reg, rdN_next, wrN_reg, wrN_next;
    logic              cs1_reg, cs1_next, cs3_reg, cs3_next, ack_reg, ack_next;
    logic [2:0]        addr_reg, addr_next;
    logic              have_reg, have_next;
    logic              isDma, isRead, pio, timeUp;

    assign isDma  = cmd_reg.op[1];
    assign isRead = !cmd_reg.op[0];
    assign pio    = xferMode == MODE_PIO;
    assign timeUp = timer_reg == 8'h00;

    assign cmdReady     = state_reg == ST_IDLE;
    assign busy         = state_reg != ST_IDLE;
    assign cmdBlockSelN = cs1_reg;
    assign ctlBlockSelN = cs3_reg;
    assign regAddr      = addr_reg;
    assign diskDataOut  = dout_reg;
    // Drive bus only on host writes
    assign diskDataOe   = oe_reg;
    assign dmaAckN      = ack_reg;
    assign readStrobeN  = rdN_reg;
    assign writeStrobeN = wrN_reg;

    always_comb begin
        state_next    = state_reg;
        cmd_next      = cmd_reg;
        words_next    = words_reg;
        timer_next    = timeUp ? 8'h00 : timer_reg - 8'h01;
        dout_next     = dout_reg;
        oe_next       = oe_reg;
        rdN_next      = rdN_reg;
        wrN_next      = wrN_reg;
        cs1_next      = cs1_reg;
        cs3_next      = cs3_reg;
        ack_next      = ack_reg;
        addr_next     = addr_reg;
        have_next     = have_reg;
        push_next     = 1'b0;
        pushData_next = pushData_reg;
        wrReady       = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (cmdValid) begin
                    cmd_next   = cmd;
                    words_next = (cmd.count == 16'h0000) ? 16'h0001 : cmd.count;
                    timer_next = SETUP_CYC;
                    // Selects for registers, acknowledge for DMA
                    if (cmd.op[1]) begin
                        cs1_next   = 1'b1;
                        cs3_next   = 1'b1;
                        ack_next   = 1'b0;
                        // Ultra bursts only in Ultra mode
                        state_next = (xferMode == MODE_UDMA) ? ST_UWAIT : ST_SETUP;
                    end else begin
                        cs1_next   = cmd.ctlBlock;
                        cs3_next   = !cmd.ctlBlock;
                        addr_next  = cmd.addr;
                        state_next = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                // DMA words wait for drive request
                if (timeUp && (!isDma || reqLvl) && (!isRead || !fifoAlmost)
                        && (isRead || !isDma || wrValid)) begin
                    timer_next = STROBE_CYC;
                    state_next = ST_STROBE;
                    if (isRead) begin
                        // Read strobe hands bus to drive
                        rdN_next = 1'b0;
                    end else begin
                        wrN_next  = 1'b0;
                        oe_next   = 1'b1;
                        dout_next = isDma ? wrData : cmd_reg.wdata;
                        wrReady   = isDma;
                    end
                end
            end
            ST_STROBE: begin
                // Ready low adds wait states in PIO
                if (timeUp && (!pio || isDma || rdyLvl)) begin
                    rdN_next   = 1'b1;
                    wrN_next   = 1'b1;
                    timer_next = RECOV_CYC;
                    state_next = ST_RECOV;
                    if (isRead) begin
                        push_next     = 1'b1;
                        pushData_next = dataS;
                    end
                end
            end
            ST_RECOV: begin
                // Data held past write strobe release
                if (timeUp) begin
                    oe_next = 1'b0;
                    if (isDma && words_reg > 16'h0001) begin
                        words_next = words_reg - 16'h0001;
                        state_next = ST_SETUP;
                    end else begin
                        cs1_next   = 1'b1;
                        cs3_next   = 1'b1;
                        ack_next   = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_UWAIT: begin
                if (reqLvl) begin
                    timer_next = HALF_CYC;
                    have_next  = 1'b0;
                    oe_next    = !isRead;
                    state_next = isRead ? ST_URD : ST_UWR;
                end
            end
            ST_URD: begin
                rdN_next = fifoAlmost;
                if (rdyEdge) begin
                    push_next     = 1'b1;
                    pushData_next = dataS;
                    words_next    = words_reg - 16'h0001;
                end
                if (words_reg == 16'h0000 || !reqLvl) begin
                    state_next = ST_USTOP;
                end
            end
            ST_UWR: begin
                if (!have_reg && wrValid && words_reg != 16'h0000) begin
                    // Word set up a half period before edge
                    dout_next  = wrData;
                    wrReady    = 1'b1;
                    have_next  = 1'b1;
                    timer_next = HALF_CYC;
                // Hold strobe while drive not ready
                end else if (have_reg && timeUp && !rdyLvl) begin
                    rdN_next   = !rdN_reg;
                    have_next  = 1'b0;
                    words_next = words_reg - 16'h0001;
                    timer_next = HALF_CYC;
                end else if (!have_reg && (words_reg == 16'h0000 || !reqLvl)) begin
                    state_next = ST_USTOP;
                end
            end
            ST_USTOP: begin
                wrN_next = 1'b1;
                if (timeUp) begin
                    rdN_next   = 1'b1;
                    oe_next    = 1'b0;
                    ack_next   = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (state_reg != ST_USTOP && state_next == ST_USTOP) begin
            timer_next = STOP_CYC;
        end
        if (state_reg == ST_UWAIT && state_next != ST_UWAIT) begin
            // Ultra write strobe idles high, stop low
            wrN_next = 1'b0;
            rdN_next = isRead ? fifoAlmost : 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= ST_IDLE;
            cmd_reg      <= '0;
            words_reg    <= 16'h0000;
            timer_reg    <= 8'h00;
            dout_reg     <= `ATA_DATA_RESET;
            oe_reg       <= 1'b0;
            rdN_reg      <= 1'b1;
            wrN_reg      <= 1'b1;
            cs1_reg      <= 1'b1;
            cs3_reg      <= 1'b1;
            ack_reg      <= 1'b1;
            addr_reg     <= 3'h0;
            have_reg     <= 1'b0;
            push_reg     <= 1'b0;
            pushData_reg <= `ATA_DATA_RESET;
        end else begin
            state_reg    <= state_next;
            cmd_reg      <= cmd_next;
            words_reg    <= words_next;
            timer_reg    <= timer_next;
            dout_reg     <= dout_next;
            oe_reg       <= oe_next;
            rdN_reg      <= rdN_next;
            wrN_reg      <= wrN_next;
            cs1_reg      <= cs1_next;
            cs3_reg      <= cs3_next;
            ack_reg      <= ack_next;
            addr_reg     <= addr_next;
            have_reg     <= have_next;
            push_reg     <= push_next;
            pushData_reg <= pushData_next;
        end
    end
endmodule // ata_host_port

// File: verification/disk_drive_model.sv
// Behavioural disk drive answering the host port pins
`timescale 1ns/1ps
module disk_drive_model (
    input  wire logic        cmdBlockSelN, // Command block select
    input  wire logic        ctlBlockSelN, // Control block select
    input  wire logic [2:0]  regAddr,      // Register address
    input  wire logic [15:0] diskDataOut,  // Host bus value
    input  wire logic        diskDataOe,   // Host drives bus
    input  wire logic        dmaAckN,      // DMA acknowledge
    input  wire logic        readStrobeN,  // Read strobe / Ultra pin
    input  wire logic        writeStrobeN, // Write strobe / stop
    input  wire logic        udma,         // Ultra mode in use
    input  wire logic        reqEn,        // Raise DMA request
    input  wire logic        waitSt,       // Hold ready low in strobes
    input  wire logic        pauseW,       // Pause Ultra writes
    output logic [15:0]      diskDataIn,   // Bus level
    output logic             dmaRequest,   // DMA request
    output logic             channelReady, // Ready / Ultra pin
    output logic [7:0]       capCount,     // Ultra words taken
    output logic [15:0]      capSum        // Sum of Ultra words
);
    // ****************************************************************
    // Drive behaviour
    // ****************************************************************
    logic [15:0] regs [16];
    logic [15:0] dmaWord = 16'hA000;
    logic [15:0] idle = 16'h5A5A;
    logic        rdy = 1'b1;
    logic        stb = 1'b0;
    logic        drv;
    logic        sel;
    initial capCount = 8'h00;
    initial capSum = 16'h0000;
    assign sel = !cmdBlockSelN || !ctlBlockSelN;
    assign drv = udma ? (!dmaAckN && !diskDataOe) : (!readStrobeN && (sel || !dmaAckN));
    assign diskDataIn = diskDataOe ? diskDataOut :
                        drv ? (sel ? regs[{cmdBlockSelN, regAddr}] : dmaWord) : idle;
    // Released bus shows the inverse, so a stale capture cannot pass
    always @(diskDataIn) if (drv) idle = ~diskDataIn;
    assign dmaRequest = reqEn;
    assign channelReady = udma ? (diskDataOe ? pauseW : stb) : rdy;
    always @(posedge writeStrobeN) if (!udma && sel) regs[{cmdBlockSelN, regAddr}] = diskDataIn;
    always @(posedge readStrobeN) if (!udma && !dmaAckN) dmaWord = dmaWord + 16'h0001;
    always @(negedge readStrobeN or negedge writeStrobeN) begin
        if (waitSt && !udma) begin
            rdy = 1'b0;
            #400 rdy = 1'b1;
        end
    end
    // 200 ns read strobe while host ready
    always begin
        #70;
        if (udma && drv && dmaRequest && !writeStrobeN && !readStrobeN) begin
            dmaWord = dmaWord + 16'h0001;
            #30 stb = ~stb;
        end else begin
            #30;
        end
    end
    always @(readStrobeN) begin
        if (udma && diskDataOe && !dmaAckN) begin
            capCount = capCount + 8'h01;
            capSum = capSum + diskDataIn;
        end
    end
endmodule // disk_drive_model

// File: verification/ata_host_port_monitor.sv
// Concurrent checks on the disk host port pins
`timescale 1ns/1ps
module ata_host_port_monitor #(
    parameter int DATA_W = 16
) (
    input wire logic                          core_clk,     // Core clock
    input wire logic                          rst_b,        // Async reset, active low
    input wire ata_host_port_pkg::xfer_mode_e xferMode,     // Transfer mode
    input wire logic                          cmdBlockSelN, // Command block select
    input wire logic                          ctlBlockSelN, // Control block select
    input wire logic [DATA_W-1:0]             diskDataOut,  // Bus drive value
    input wire logic                          diskDataOe,   // Bus drive enable
    input wire logic                          dmaAckN,      // DMA acknowledge
    input wire logic                          readStrobeN,  // Read strobe / Ultra pin
    input wire logic                          writeStrobeN, // Write strobe / stop
    input wire logic                          channelReady  // Ready / Ultra pin
);
    import ata_host_port_pkg::*;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [3:0] lowCnt_reg;
    logic [3:0] lowCnt_next;
    // Saturates so long waits never wrap
    always_comb begin
        lowCnt_next = (lowCnt_reg == 4'hF) ? 4'hF : lowCnt_reg + 4'h1;
        if (channelReady) begin
            lowCnt_next = 4'h0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt_reg <= 4'h0;
        end else begin
            lowCnt_reg <= lowCnt_next;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence stop_held;
        (writeStrobeN && !dmaAckN) [*3];
    endsequence
    sequence stop_done;
        writeStrobeN && dmaAckN;
    endsequence
    blocks_excl_a: assert property (!cmdBlockSelN |-> ctlBlockSelN)
        else $error("both register blocks selected");
    sel_ack_excl_a: assert property (!dmaAckN |-> cmdBlockSelN && ctlBlockSelN)
        else $error("select and acknowledge together");
    strobe_addressed_a: assert property (
        $fell(readStrobeN) || $fell(writeStrobeN) |-> !cmdBlockSelN || !ctlBlockSelN || !dmaAckN)
        else $error("strobe without select or acknowledge");
    write_hold_a: assert property (
        $rose(writeStrobeN) && xferMode != MODE_UDMA |-> diskDataOe && $stable(diskDataOut))
        else $error("write data not held at strobe release");
    read_bus_free_a: assert property (
        !readStrobeN && xferMode != MODE_UDMA |-> !diskDataOe)
        else $error("host drives bus during read strobe");
    pio_wait_a: assert property (
        xferMode == MODE_PIO && dmaAckN && !writeStrobeN && lowCnt_reg >= 4'h6 |=> !writeStrobeN)
        else $error("write strobe ended while not ready");
    stop_seq_a: assert property (
        $rose(writeStrobeN) && !dmaAckN && xferMode == MODE_UDMA |-> stop_held ##[1:4] stop_done)
        else $error("burst stop sequence wrong");
    udma_pause_a: assert property (
        (xferMode == MODE_UDMA && diskDataOe && !dmaAckN && channelReady) [*6]
        |=> $stable(readStrobeN))
        else $error("write strobe moved while drive paused");
    udma_edge_a: assert property (
        xferMode == MODE_UDMA && diskDataOe && !dmaAckN && $changed(readStrobeN)
        |-> $stable(diskDataOut))
        else $error("write data changed with strobe edge");
endmodule // ata_host_port_monitor

bind ata_host_port ata_host_port_monitor #(.DATA_W(DATA_W)) monitor (
    .core_clk, .rst_b, .xferMode, .cmdBlockSelN, .ctlBlockSelN, .diskDataOut,
    .diskDataOe, .dmaAckN, .readStrobeN, .writeStrobeN, .channelReady
);

// File: verification/ata_host_port_tb.sv
// Self-checking bench for the disk host port
`timescale 1ns/1ps
module ata_host_port_tb;
    import ata_host_port_pkg::*;
    logic        core_clk, rst_b, cmdValid, cmdReady, wrValid, wrReady, rdValid;
    logic        rdReady, busy, cmdBlockSelN, ctlBlockSelN, diskDataOe, dmaRequest;
    logic        dmaAckN, readStrobeN, writeStrobeN, channelReady, reqEn, waitSt, pauseW;
    xfer_mode_e  xferMode;
    cmd_s        cmd;
    logic [15:0] wrData, rdData, diskDataIn, diskDataOut, capSum;
    logic [2:0]  regAddr;
    logic [7:0]  capCount;
    int          failures, compares;
    ata_host_port DUT (
        .core_clk, .rst_b, .xferMode, .cmdValid, .cmdReady, .cmd, .wrValid, .wrReady,
        .wrData, .rdValid, .rdReady, .rdData, .busy, .cmdBlockSelN, .ctlBlockSelN,
        .regAddr, .diskDataIn, .diskDataOut, .diskDataOe, .dmaRequest, .dmaAckN,
        .readStrobeN, .writeStrobeN, .channelReady
    );
    disk_drive_model drive (
        .cmdBlockSelN, .ctlBlockSelN, .regAddr, .diskDataOut, .diskDataOe, .dmaAckN,
        .readStrobeN, .writeStrobeN, .udma(xferMode == MODE_UDMA), .reqEn, .waitSt,
        .pauseW, .diskDataIn, .dmaRequest, .channelReady, .capCount, .capSum
    );
    always #12.5 core_clk = ~core_clk;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bounded(input string what, input int k);
        if (k >= 4000) begin
            check(what, 16'h0000, 16'h0001);
            wrap_up();
        end
    endtask
    task automatic issue(input op_e op, input logic ctl, input logic [2:0] a,
                         input logic [15:0] d, input logic [15:0] n);
        int k;
        for (k = 0; !cmdReady && k < 4000; k++) tick();
        bounded("command port", k);
        cmdValid = 1'b1;
        cmd = '{op, ctl, a, d, n};
        tick();
        cmdValid = 1'b0;
        check("busy", 16'(busy), 16'h0001);
    endtask
    task automatic settle(output int low);
        int k;
        low = 0;
        for (k = 0; !cmdReady && k < 4000; k++) begin
            if (!writeStrobeN) low++;
            tick();
        end
        bounded("command done", k);
    endtask
    task automatic pop(input logic [15:0] exp);
        int k;
        tick();
        for (k = 0; !rdValid && k < 4000; k++) tick();
        bounded("read word", k);
        check("read word", rdData, exp);
        rdReady = 1'b1;
        tick();
        rdReady = 1'b0;
    endtask
    task automatic feed(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            wrValid = 1'b1;
            wrData = 16'hB000 + 16'(i);
            k = 0;
            do begin
                @(posedge core_clk);
                k++;
            end while (!wrReady && k < 4000);
            bounded("write word", k);
            #2;
        end
        wrValid = 1'b0;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic reg_access();
        int low;
        issue(OP_REG_WR, 1'b0, 3'h3, 16'h1234, 16'h0001);
        issue(OP_REG_WR, 1'b1, 3'h6, 16'hC0DE, 16'h0001);
        issue(OP_REG_RD, 1'b1, 3'h6, 16'h0000, 16'h0001);
        pop(16'hC0DE);
        issue(OP_REG_RD, 1'b0, 3'h3, 16'h0000, 16'h0001);
        pop(16'h1234);
        settle(low);
    endtask
    task automatic wait_states();
        int low;
        waitSt = 1'b1;
        issue(OP_REG_WR, 1'b0, 3'h1, 16'h00FF, 16'h0001);
        settle(low);
        waitSt = 1'b0;
        check("strobe stretch", 16'(low >= 16), 16'h0001);
    endtask
    task automatic mdma_read();
        int low;
        xferMode = MODE_MDMA;
        reqEn = 1'b1;
        issue(OP_DMA_RD, 1'b0, 3'h0, 16'h0000, 16'h0002);
        pop(16'hA000);
        pop(16'hA001);
        settle(low);
    endtask
    task automatic udma_write();
        int low;
        xferMode = MODE_UDMA;
        pauseW = 1'b1;
        issue(OP_DMA_WR, 1'b0, 3'h0, 16'h0000, 16'h0004);
        fork
            feed(4);
            begin
                repeat (40) tick();
                check("paused burst", 16'(capCount), 16'h0000);
                pauseW = 1'b0;
            end
        join
        settle(low);
        check("burst words", 16'(capCount), 16'h0004);
        check("burst sum", capSum, 16'hC006);
    endtask
    task automatic udma_read();
        int low;
        issue(OP_DMA_RD, 1'b0, 3'h0, 16'h0000, 16'h0010);
        // Reader stalls so the FIFO reaches almost full and the burst must pause
        repeat (120) tick();
        check("read pause", {14'h0000, readStrobeN, cmdReady}, 16'h0002);
        for (int i = 0; i < 16; i++) pop(16'hA003 + 16'(i));
        settle(low);
        check("stop released", 16'(writeStrobeN && dmaAckN), 16'h0001);
    endtask
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        failures = 0;
        compares = 0;
        {cmdValid, wrValid, rdReady, reqEn, waitSt, pauseW} = 6'h00;
        cmd = '0;
        wrData = 16'h0000;
        xferMode = MODE_PIO;
        repeat (5) @(posedge core_clk);
        #2 rst_b = 1'b1;
        repeat (3) tick();
        reg_access();
        wait_states();
        mdma_read();
        udma_write();
        udma_read();
        wrap_up();
    end
endmodule // ata_host_port_tb
